/* File: shared/ucm_pkg.sv */
package ucm_pkg;
   // ****************************************
   // bus and register map
   // ****************************************
   localparam int          DATA_W     = 32;
   localparam int          ADDR_W     = 4;
   localparam logic [3:0]  CTRL_ADDR  = 4'h0;
   localparam logic [3:0]  STAT_ADDR  = 4'h4;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLV   = 2'h2;
   localparam int          CTRL_W     = 2;
   localparam int          STAT_W     = 11;

   // ****************************************
   // timing
   // ****************************************
   localparam int          CLK_HZ         = 20_000_000;
   localparam int          DISCHARGE_US   = 100;
   localparam int          DEGLITCH_US    = 150;
   localparam int          DSC_CYC        = DISCHARGE_US * (CLK_HZ / 1_000_000);
   localparam int          DEG_CYC        = DEGLITCH_US * (CLK_HZ / 1_000_000);
   localparam int          CNT_W          = 12;
   localparam logic [11:0] DSC_LAST       = 12'(DSC_CYC - 1);
   localparam logic [11:0] DEG_LAST       = 12'(DEG_CYC - 1);

   // ****************************************
   // types
   // ****************************************
   typedef enum logic [2:0] {
      MODE_OFF, MODE_DCP_AUTO, MODE_DCP_BC12, MODE_DCP_DIV, MODE_SDP, MODE_CDP
   } ucm_mode_e;

   typedef struct packed {
      logic force_discharge;
      logic variant_b;
   } ucm_ctrl_s;

   typedef struct packed {
      logic      auto_bc12;
      logic      data_switch;
      logic      const_current;
      logic      uv_ok;
      logic      therm_off;
      logic      fault;
      logic      discharging;
      logic      switch_on;
      ucm_mode_e mode;
   } ucm_stat_s;

   typedef struct packed {
      logic [2:0] mode_select;
      logic       enable;
      logic       discharge_request;
      logic       limit_threshold_select;
      logic       overcurrent;
      logic       die_over_first;
      logic       die_over_second;
      logic       die_cooled;
      logic       vin_above_on;
      logic       vin_above_off;
      logic       bc12_attached;
   } ucm_pins_s;

   // select1 is bit 0, select3 is bit 2
   function automatic ucm_mode_e decode_mode(input logic [2:0] s,
                                             input logic       var_b);
      ucm_mode_e m;
      m = MODE_OFF;
      if (var_b)
      begin
         unique case (s[1:0])
            2'b00:   m = MODE_DCP_AUTO;
            2'b10:   m = MODE_DCP_BC12;
            2'b01:   m = MODE_DCP_DIV;
            2'b11:   m = s[2] ? MODE_CDP : MODE_SDP;
         endcase
      end
      else if (s == 3'b000)
         m = MODE_OFF;
      else if (!s[0] && s[2])
         m = MODE_DCP_AUTO;
      else if (s[1] && !s[2])
         m = MODE_SDP;
      else if (s == 3'b001)
         m = MODE_DCP_BC12;
      else if (s == 3'b101)
         m = MODE_DCP_DIV;
      else
         m = MODE_CDP;
      return m;
   endfunction : decode_mode

   function automatic logic is_port_mode(input ucm_mode_e m);
      return (m == MODE_SDP) || (m == MODE_CDP);
   endfunction : is_port_mode
endpackage : ucm_pkg

/* File: shared/ucm_reg_if.sv */
interface ucm_reg_if;
   ucm_pkg::ucm_ctrl_s ctrl;
   ucm_pkg::ucm_stat_s stat;

   modport regs (output ctrl, input stat);
   modport core (input ctrl, output stat);
endinterface : ucm_reg_if

/* File: rtl/ucm_axil_regs.sv */
module ucm_axil_regs (
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   input  wire logic [ucm_pkg::ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output      logic                        s_axi_awready,
   input  wire logic [ucm_pkg::DATA_W-1:0]  s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output      logic                        s_axi_wready,
   output      logic [1:0]                  s_axi_bresp,
   output      logic                        s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   input  wire logic [ucm_pkg::ADDR_W-1:0]  s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output      logic                        s_axi_arready,
   output      logic [ucm_pkg::DATA_W-1:0]  s_axi_rdata,
   output      logic [1:0]                  s_axi_rresp,
   output      logic                        s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   ucm_reg_if.regs                          rif
);
   logic                        aw_held;
   logic                        w_held;
   logic [ucm_pkg::ADDR_W-1:0]  aw_addr;
   logic [ucm_pkg::DATA_W-1:0]  w_data;
   logic                        w_lane0;
   logic                        do_write;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write      = aw_held && w_held;

   // ****************************************
   // write channel
   // ****************************************
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= '0;
         w_data  <= '0;
         w_lane0 <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         else if (do_write)
            aw_held <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held  <= 1'b1;
            w_data  <= s_axi_wdata;
            w_lane0 <= s_axi_wstrb[0];
         end
         else if (do_write)
            w_held <= 1'b0;
      end

   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= ucm_pkg::RESP_OKAY;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (aw_addr == ucm_pkg::CTRL_ADDR) ?
                         ucm_pkg::RESP_OKAY : ucm_pkg::RESP_SLV;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;

   // force bit is a one-cycle kick, never stored
   always_ff @(posedge aclk)
      if (!aresetn)
         rif.ctrl <= '0;
      else
      begin
         rif.ctrl.force_discharge <= 1'b0;
         if (do_write && w_lane0 && aw_addr == ucm_pkg::CTRL_ADDR)
            rif.ctrl <= w_data[ucm_pkg::CTRL_W-1:0];
      end

   // ****************************************
   // read channel
   // ****************************************
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= ucm_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= ucm_pkg::RESP_OKAY;
         s_axi_rdata  <= '0;
         if (s_axi_araddr == ucm_pkg::CTRL_ADDR)
            s_axi_rdata[ucm_pkg::CTRL_W-1:0] <= {1'b0, rif.ctrl.variant_b};
         else if (s_axi_araddr == ucm_pkg::STAT_ADDR)
            s_axi_rdata[ucm_pkg::STAT_W-1:0] <= rif.stat;
         else
            s_axi_rresp <= ucm_pkg::RESP_SLV;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
endmodule : ucm_axil_regs

/* File: rtl/ucm_charge_ctrl.sv */
module ucm_charge_ctrl (
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   input  wire logic [ucm_pkg::ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output      logic                        s_axi_awready,
   input  wire logic [ucm_pkg::DATA_W-1:0]  s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output      logic                        s_axi_wready,
   output      logic [1:0]                  s_axi_bresp,
   output      logic                        s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   input  wire logic [ucm_pkg::ADDR_W-1:0]  s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output      logic                        s_axi_arready,
   output      logic [ucm_pkg::DATA_W-1:0]  s_axi_rdata,
   output      logic [1:0]                  s_axi_rresp,
   output      logic                        s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   input  wire logic [2:0]                  mode_select,
   input  wire logic                        enable,
   input  wire logic                        discharge_request,
   input  wire logic                        limit_threshold_select,
   input  wire logic                        overcurrent,
   input  wire logic                        die_over_first,
   input  wire logic                        die_over_second,
   input  wire logic                        die_cooled,
   input  wire logic                        vin_above_on,
   input  wire logic                        vin_above_off,
   input  wire logic                        bc12_attached,
   output      logic                        power_switch_on,
   output      logic                        discharge_on,
   output      logic                        data_switch_on,
   output      logic                        limit_resistor_second,
   output      logic                        const_current,
   output      logic                        dcp_short_on,
   output      logic                        dcp_divider_on,
   output      logic                        fault_n_out,
   output      logic                        fault_n_oe
);
   typedef enum logic [1:0] {ST_IDLE, ST_ON, ST_DSC} ucm_state_e;

   ucm_reg_if                rif ();
   ucm_pkg::ucm_pins_s       pins_raw;
   ucm_pkg::ucm_pins_s       pins_m;
   ucm_pkg::ucm_pins_s       pins;
   ucm_pkg::ucm_mode_e       mode;
   ucm_pkg::ucm_mode_e       prev_mode;
   ucm_state_e               state;
   logic [ucm_pkg::CNT_W-1:0] dsc_cnt;
   logic [ucm_pkg::CNT_W-1:0] deg_cnt;
   logic                     var_b;
   logic                     uv_ok;
   logic                     therm_off;
   logic                     auto_bc12;
   logic                     limiting;
   logic                     ilim_fault;
   logic                     hold_dsc;
   logic                     run_ok;
   logic                     mode_trig;
   logic                     attach_ev;
   logic                     trig;
   logic                     therm_trip;

   ucm_axil_regs u_regs (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .rif           (rif.regs)
   );

   // ****************************************
   // pin synchronisers
   // ****************************************
   assign pins_raw = {mode_select, enable, discharge_request,
                      limit_threshold_select, overcurrent, die_over_first,
                      die_over_second, die_cooled, vin_above_on,
                      vin_above_off, bc12_attached};
   assign var_b    = rif.ctrl.variant_b;

   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         pins_m <= '0;
         pins   <= '0;
      end
      else
      begin
         pins_m <= pins_raw;
         pins   <= pins_m;
      end

   // ****************************************
   // mode decode and history
   // ****************************************
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         mode      <= ucm_pkg::MODE_OFF;
         prev_mode <= ucm_pkg::MODE_OFF;
      end
      else
      begin
         mode      <= ucm_pkg::decode_mode(pins.mode_select, var_b);
         prev_mode <= mode;
      end

   // variant B holds the output discharged while its request input is low
   assign hold_dsc  = (!var_b && mode == ucm_pkg::MODE_OFF) ||
                      (var_b && !pins.discharge_request);
   assign run_ok    = uv_ok && !therm_off && !hold_dsc;
   assign mode_trig = (mode != prev_mode) &&
                      (ucm_pkg::is_port_mode(mode) ||
                       ucm_pkg::is_port_mode(prev_mode));
   assign attach_ev = (mode == ucm_pkg::MODE_DCP_AUTO) &&
                      pins.bc12_attached && !auto_bc12;
   assign trig      = mode_trig || attach_ev || rif.ctrl.force_discharge;

   // ****************************************
   // auto-detect tracking
   // ****************************************
   always_ff @(posedge aclk)
      if (!aresetn)
         auto_bc12 <= 1'b0;
      else if (mode != ucm_pkg::MODE_DCP_AUTO || !pins.bc12_attached)
         auto_bc12 <= 1'b0;
      else
         auto_bc12 <= 1'b1;

   // ****************************************
   // undervoltage lockout with hysteresis
   // ****************************************
   always_ff @(posedge aclk)
      if (!aresetn)
         uv_ok <= 1'b0;
      else if (pins.vin_above_on)
         uv_ok <= 1'b1;
      else if (!pins.vin_above_off)
         uv_ok <= 1'b0;

   // ****************************************
   // thermal shutdown
   // ****************************************
   assign limiting   = pins.overcurrent && power_switch_on;
   assign therm_trip = (pins.die_over_first && limiting) ||
                       pins.die_over_second;

   // trip beats cooled so a hot die never restarts early
   always_ff @(posedge aclk)
      if (!aresetn)
         therm_off <= 1'b0;
      else if (therm_trip)
         therm_off <= 1'b1;
      else if (pins.die_cooled)
         therm_off <= 1'b0;

   // ****************************************
   // discharge sequencer
   // ****************************************
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         state   <= ST_IDLE;
         dsc_cnt <= '0;
      end
      else
         unique case (state)
            ST_IDLE:
               if (run_ok)
                  state <= ST_ON;
            ST_ON:
               if (!run_ok)
                  state <= ST_IDLE;
               else if (trig)
               begin
                  state   <= ST_DSC;
                  dsc_cnt <= ucm_pkg::DSC_LAST;
               end
            ST_DSC:
               if (dsc_cnt == '0)
                  state <= run_ok ? ST_ON : ST_IDLE;
               else
                  dsc_cnt <= dsc_cnt - 1'b1;
         endcase

   // ****************************************
   // current limit deglitch
   // ****************************************
   // inrush into a large load must not flag a fault
   always_ff @(posedge aclk)
      if (!aresetn)
         deg_cnt <= '0;
      else if (!limiting)
         deg_cnt <= '0;
      else if (deg_cnt != ucm_pkg::DEG_LAST)
         deg_cnt <= deg_cnt + 1'b1;

   assign ilim_fault = limiting && deg_cnt == ucm_pkg::DEG_LAST;

   // ****************************************
   // registered outputs
   // ****************************************
   always_ff @(posedge aclk)
      if (!aresetn)
      begin
         power_switch_on       <= 1'b0;
         discharge_on          <= 1'b0;
         data_switch_on        <= 1'b0;
         limit_resistor_second <= 1'b0;
         const_current         <= 1'b0;
         dcp_short_on          <= 1'b0;
         dcp_divider_on        <= 1'b0;
         fault_n_oe            <= 1'b0;
      end
      else
      begin
         power_switch_on <= state == ST_ON && run_ok;
         discharge_on    <= state == ST_DSC || hold_dsc;
         data_switch_on  <= ucm_pkg::is_port_mode(mode) &&
                            (var_b ? pins.discharge_request : pins.enable);
         limit_resistor_second <= pins.limit_threshold_select;
         const_current   <= limiting;
         dcp_short_on    <= mode == ucm_pkg::MODE_DCP_BC12 ||
                            (mode == ucm_pkg::MODE_DCP_AUTO && auto_bc12);
         dcp_divider_on  <= mode == ucm_pkg::MODE_DCP_DIV ||
                            (mode == ucm_pkg::MODE_DCP_AUTO && !auto_bc12);
         fault_n_oe      <= therm_trip || therm_off || ilim_fault;
      end

   assign fault_n_out = 1'b0;

   assign rif.stat = '{auto_bc12:     auto_bc12,
                       data_switch:   data_switch_on,
                       const_current: const_current,
                       uv_ok:         uv_ok,
                       therm_off:     therm_off,
                       fault:         fault_n_oe,
                       discharging:   discharge_on,
                       switch_on:     power_switch_on,
                       mode:          mode};

   // ****************************************
   // checks
   // ****************************************
   off_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (!var_b && mode == ucm_pkg::MODE_OFF) |=>
      (!power_switch_on && discharge_on && !data_switch_on))
      else $error("off code left switch or data path on");

   auto_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (!var_b && $stable(var_b) && !pins.mode_select[0] &&
       pins.mode_select[2]) |=> mode == ucm_pkg::MODE_DCP_AUTO)
      else $error("variant A auto-detect code misdecoded");

   sdp_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (!var_b && $stable(var_b) && pins.mode_select[1] &&
       !pins.mode_select[2]) |=> mode == ucm_pkg::MODE_SDP)
      else $error("variant A SDP code misdecoded");

   b_codes_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (var_b && pins.mode_select[1:0] == 2'b11) |=>
      mode == ($past(pins.mode_select[2]) ? ucm_pkg::MODE_CDP
                                          : ucm_pkg::MODE_SDP))
      else $error("variant B port code misdecoded");

   dsc_enter_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state == ST_ON && run_ok && mode_trig) |=>
      state == ST_DSC ##1 (!power_switch_on && discharge_on))
      else $error("port mode change did not discharge");

   sw_restore_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state == ST_DSC && dsc_cnt == '0 && run_ok && $stable(run_ok)) |=>
      state == ST_ON || !run_ok)
      else $error("switch not restored after discharge");

   undervoltage_lockout_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (!uv_ok && !pins.vin_above_on) |=> ##1 !power_switch_on)
      else $error("switch on during lockout");

   hot_trip_a: assert property (@(posedge aclk) disable iff (!aresetn)
      pins.die_over_second |=> (therm_off && fault_n_oe) ##1 !power_switch_on)
      else $error("second monitor did not shut down");

   fault_fast_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (limiting && !therm_trip && !therm_off &&
       deg_cnt < ucm_pkg::DEG_LAST - 1) |=> !fault_n_oe)
      else $error("limit fault not deglitched");

   data_path_a: assert property (@(posedge aclk) disable iff (!aresetn)
      data_switch_on |-> ucm_pkg::is_port_mode($past(mode)))
      else $error("data switch closed outside port modes");

   limit_cc_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (pins.overcurrent && power_switch_on) |=> const_current)
      else $error("overcurrent without constant current");

   hot_first_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (pins.die_over_first && limiting) |=> therm_off ##1 !power_switch_on)
      else $error("first monitor did not shut down");

   flt_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (!therm_trip && !therm_off && !limiting) |=> !fault_n_oe)
      else $error("fault flag held after cause cleared");

   lim_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
      limit_resistor_second == $past(pins.limit_threshold_select))
      else $error("limit threshold select not followed");
endmodule : ucm_charge_ctrl

/* File: sim/ucm_host_model.sv */
module ucm_host_model (
   input  wire logic       aclk,
   input  wire logic       vb,
   input  wire logic [4:0] req,
   output      logic [2:0] mode_select = 3'h0,
   output      logic       discharge_request = 1'h1
);
   timeunit 1ns;
   timeprecision 1ns;
   // req[4] set: pins follow power state req[0] and, when vb is low, adapter req[1]
   always @(posedge aclk)
   begin
      discharge_request <= !req[3];
      if (!req[4])
         mode_select <= req[2:0];
      else if (vb)
         mode_select <= req[0] ? 3'h7 : 3'h0;
      else if (req[1])
         mode_select <= req[0] ? 3'h7 : 3'h4;
      else
         mode_select <= req[0] ? 3'h2 : 3'h0;
   end
endmodule : ucm_host_model

/* File: sim/usb_charge_mode_control_tb.sv */
module usb_charge_mode_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [2:0] mode_select;
   logic s_axi_rvalid, enable = 1, discharge_request, vb = 0;
   logic limit_threshold_select = 0, overcurrent = 0, die_over_first = 0;
   logic die_over_second = 0, die_cooled = 0, vin_above_on = 0;
   logic vin_above_off = 0, bc12_attached = 0, power_switch_on;
   logic discharge_on, data_switch_on, const_current, limit_resistor_second;
   logic dcp_short_on, dcp_divider_on, fault_n_out, fault_n_oe;
   logic [4:0] req = 0;
   int num_errors = 0, n_tests = 0, i;
   ucm_charge_ctrl u_dut (.*);
   ucm_host_model u_host (.aclk, .vb, .req, .mode_select, .discharge_request);
   always #25 aclk = ~aclk;
   // ****************************************
   // bus tasks and checks
   // ****************************************
   task automatic wt(input int n);
      repeat (n) @(posedge aclk);
   endtask : wt
   task automatic chk(input string n, input logic [31:0] s, e);
      n_tests++;
      if (s !== e)
      begin
         num_errors++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask : chk
   task automatic axw(input logic [3:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 0;
         if (s_axi_wready)
            s_axi_wvalid <= 0;
      end
      while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 0;
   endtask : axw
   task automatic axr(input logic [3:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 0;
      end
      while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 0;
   endtask : axr
   function automatic logic [2:0] em(input logic [2:0] s, input logic b);
      if (b)
         return {s[0], s[1]} == 3 ? (s[2] ? 5 : 4) : {s[0], s[1]} + 1;
      return s == 0 ? 0 : !s[0] && s[2] ? 1 : s[1] && !s[2] ? 4
           : s == 1 ? 2 : s == 5 ? 3 : 5;
   endfunction : em
   task automatic print_verdict;
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : print_verdict
   initial
   begin
      #3_000_000;
      num_errors++;
      print_verdict;
   end
   initial
   begin
      void'($urandom(32'hd96c_841f));
      wt(12);
      aresetn <= 1;
      wt(8);
      chk("dsc", discharge_on, 1);
      chk("dsw", data_switch_on, 0);
      chk("sw", power_switch_on, 0);
      req <= 5'h04;
      vin_above_on <= 1;
      vin_above_off <= 1;
      wt(10);
      chk("sw", power_switch_on, 1);
      vin_above_on <= 0;
      wt(10);
      chk("sw", power_switch_on, 1);
      vin_above_off <= 0;
      wt(10);
      chk("sw", power_switch_on, 0);
      vin_above_on <= 1;
      vin_above_off <= 1;
      // codes in order first, then random ones, for each variant
      for (i = 0; i < 48; i++)
      begin
         if (i % 24 == 0)
            axw(ucm_pkg::CTRL_ADDR, i / 24);
         vb <= i >= 24;
         req <= 5'(i % 24 < 8 ? i % 24 : $urandom % 8);
         wt(10);
         axr(ucm_pkg::STAT_ADDR);
         chk("mode", d[2:0], em(req[2:0], vb));
         chk("dsw", data_switch_on, em(req[2:0], vb) > 3);
      end
      req <= 5'h0f;
      wt(10);
      chk("dsc", discharge_on, 1);
      chk("dsw", data_switch_on, 0);
      axw(ucm_pkg::CTRL_ADDR, 0);
      vb <= 0;
      req <= 5'h12;
      wt(2100);
      chk("div", dcp_divider_on, 1);
      req <= 5'h13;
      wt(8);
      chk("sw", power_switch_on, 0);
      chk("dsc", discharge_on, 1);
      wt(2010);
      chk("sw", power_switch_on, 1);
      chk("dsc", discharge_on, 0);
      $display("test modes done");
      req <= 5'h04;
      wt(2100);
      bc12_attached <= 1;
      wt(8);
      chk("dsc", discharge_on, 1);
      wt(2010);
      chk("short", dcp_short_on, 1);
      bc12_attached <= 0;
      wt(8);
      chk("div", dcp_divider_on, 1);
      for (i = 0; i < 4; i++)
      begin
         limit_threshold_select <= 1'($urandom);
         wt(5);
         chk("lim", limit_resistor_second, limit_threshold_select);
      end
      overcurrent <= 1;
      wt(10);
      chk("cc", const_current, 1);
      chk("flt", fault_n_oe, 0);
      wt(3000);
      chk("flt", fault_n_oe, 1);
      chk("fltq", fault_n_out, 0);
      overcurrent <= 0;
      die_over_first <= 1;
      wt(10);
      chk("flt", fault_n_oe, 0);
      chk("sw", power_switch_on, 1);
      overcurrent <= 1;
      wt(6);
      chk("sw", power_switch_on, 0);
      chk("flt", fault_n_oe, 1);
      overcurrent <= 0;
      die_over_first <= 0;
      die_cooled <= 1;
      wt(2100);
      die_over_second <= 1;
      wt(6);
      chk("sw", power_switch_on, 0);
      chk("flt", fault_n_oe, 1);
      die_over_second <= 0;
      wt(2100);
      chk("sw", power_switch_on, 1);
      $display("test faults done");
      axw(ucm_pkg::STAT_ADDR, 1);
      chk("bresp", r, ucm_pkg::RESP_SLV);
      axr(4'hc);
      chk("rresp", r, ucm_pkg::RESP_SLV);
      axr(ucm_pkg::CTRL_ADDR);
      chk("ctrl", d, 0);
      for (i = 0; i < 4; i++)
      begin
         if (i == 2)
            axw(ucm_pkg::CTRL_ADDR, 1);
         vb <= i > 1;
         req <= 5'h10 | 5'(i % 2);
         wt(10);
         axr(ucm_pkg::STAT_ADDR);
         chk("host", d[2:0], i % 2 ? 4 + i / 2 : i / 2);
      end
      $display("test bus done");
      print_verdict;
   end
endmodule : usb_charge_mode_control_tb
